//--- dtc_pkg.sv
package dtc_pkg;

    // Bus geometry
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          NUM_HALVES      = 2;

    // Register byte offsets
    localparam logic [11:0] OFF_CFG         = 12'h000;
    localparam logic [11:0] OFF_CTL         = 12'h00c;
    localparam logic [11:0] OFF_MASK        = 12'h018;
    localparam logic [11:0] OFF_RAW         = 12'h01c;
    localparam logic [11:0] OFF_MIS         = 12'h020;
    localparam logic [11:0] OFF_CLR         = 12'h024;

    // Control fields, per half except the single clock enable; the B half sits one stride above the A half
    localparam int          CTL_HALF_STRIDE = 8;
    localparam int          CTL_EN          = 0;
    localparam int          CTL_STALL       = 1;
    localparam int          CTL_EDGE        = 2;
    localparam int          CTL_CLK_EN      = 4;
    localparam int          CTL_TRIG        = 5;
    localparam int          CTL_PWM         = 6;

    // Event bit positions, shared by mask, raw, masked and clear registers
    localparam int          EVT_A_TIMEOUT   = 0;
    localparam int          EVT_A_MATCH     = 1;
    localparam int          EVT_A_CAPTURE   = 2;
    localparam int          EVT_CLOCK       = 3;
    localparam int          EVT_B_TIMEOUT   = 8;
    localparam int          EVT_B_MATCH     = 9;
    localparam int          EVT_B_CAPTURE   = 10;
    localparam int          EVT_W           = 11;

    // Writable bits and reset values
    localparam logic [31:0] CFG_WR_MASK     = 32'h0000_0007;
    localparam logic [31:0] CTL_WR_MASK     = 32'h0000_6f7f;
    localparam logic [10:0] EVT_WR_MASK     = 11'h70f;
    localparam logic [2:0]  CFG_RST         = 3'h0;
    localparam logic [14:0] CTL_RST         = 15'h0000;
    localparam logic [10:0] EVT_RST         = 11'h000;

    // Global configuration codes
    localparam logic [2:0]  CFG_WIDE        = 3'h0;
    localparam logic [2:0]  CFG_CLOCK       = 3'h1;
    localparam int          CFG_SPLIT_BIT   = 2;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'h0,
        EDGE_FALL = 2'h1,
        EDGE_RSVD = 2'h2,
        EDGE_BOTH = 2'h3
    } dtc_edge_type;

endpackage : dtc_pkg

//--- dtc_half_if.sv
interface dtc_half_if;
    import dtc_pkg::*;

    logic         enable;
    logic         stall_en;
    dtc_edge_type edge_sel;
    logic         trig_en;
    logic         pwm_pol;
    logic         run;
    logic         cap_edge;

    modport ctrl (output enable, output stall_en, output edge_sel, output trig_en,
                  output pwm_pol, input run, input cap_edge);
    modport half (input enable, input stall_en, input edge_sel, input trig_en,
                  input pwm_pol, output run, output cap_edge);
endinterface : dtc_half_if

//--- dtc_half.sv
module dtc_half (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic capture_pin,
    input  wire logic pwm_raw,
    input  wire logic trig_raw,
    input  wire logic debug_halt,
    output logic      pwm_out,
    output logic      trig_out,
    dtc_half_if.half  h
);
    import dtc_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic pwm;
        logic trig;
        logic cap;
        logic run;
    } dtc_half_state_type;

    dtc_half_state_type st;
    dtc_half_state_type next_st;
    logic               rise;
    logic               fall;

    // Pin passes two flops; only s2 and prev feed the edge logic
    always_comb begin
        next_st      = st;
        next_st.s1   = capture_pin;
        next_st.s2   = st.s1;
        next_st.prev = st.s2;
        rise         = st.s2 & ~st.prev;
        fall         = ~st.s2 & st.prev;
        next_st.pwm  = pwm_raw ^ h.pwm_pol;
        next_st.trig = trig_raw & h.trig_en;
        // Halted core freezes the half only when stalling is allowed
        next_st.run  = h.enable & ~(h.stall_en & debug_halt);
        case (h.edge_sel)
            EDGE_RISE: next_st.cap = h.enable & rise;
            EDGE_FALL: next_st.cap = h.enable & fall;
            EDGE_BOTH: next_st.cap = h.enable & (rise | fall);
            default:   next_st.cap = 1'b0; // Reserved code never fires
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pwm_out    = st.pwm;
    assign trig_out   = st.trig;
    assign h.run      = st.run;
    assign h.cap_edge = st.cap;

    property p_pwm_level;
        @(posedge aclk) disable iff (!aresetn)
        h.pwm_pol |=> (pwm_out != $past(pwm_raw));
    endproperty
    a_pwm_level: assert property (p_pwm_level) else $error("pwm not inverted");

    property p_trig_gate;
        @(posedge aclk) disable iff (!aresetn)
        !h.trig_en |=> !trig_out;
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger leaked");

    property p_edge_rsvd;
        @(posedge aclk) disable iff (!aresetn)
        (h.edge_sel == EDGE_RSVD || !h.enable) |=> !h.cap_edge;
    endproperty
    a_edge_rsvd: assert property (p_edge_rsvd) else $error("capture on bad code");

    property p_stall;
        @(posedge aclk) disable iff (!aresetn)
        (h.enable && !(h.stall_en && debug_halt)) |=> h.run;
    endproperty
    a_stall: assert property (p_stall) else $error("half not running");

    property p_halt_freeze;
        @(posedge aclk) disable iff (!aresetn)
        (h.stall_en && debug_halt) |=> !h.run;
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("half ran in halt");

endmodule : dtc_half

//--- dtc_top.sv
// Operation
// - B PWM output inverted when bit 14 set
// - B trigger passes only while bit 13 set
// - B capture edge select, bits 11:10
// - B stall allowed only when bit 9 set
// - Bit 8 enables the B half
// - A PWM output inverted when bit 6 set
// - A trigger passes only while bit 5 set
// - Clock counter advances only while bit 4 set
// - A capture edge select, bits 3:2
// - A stall allowed only when bit 1 set
// - Bit 0 enables the A half
// - Reserved control bits read-only; writable reset zero
// - Mask bit 1 enables source; resets zero
// - B mask bits at 10, 9, 8
// - A/clock mask bits at 3..0; rest reserved
// - Configuration field picks wide, clock, split
// - Raw status set by event, W1C clear
// - Masked status is raw AND mask
module dtc_top (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite slave
    input  wire logic [dtc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [dtc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Timer side; index 0 is the A half, index 1 the B half
    input  wire logic [dtc_pkg::EVT_W-1:0] timer_event,
    input  wire logic                   debug_halt,
    input  wire logic [1:0]             capture_pin,
    input  wire logic [1:0]             pwm_raw,
    input  wire logic [1:0]             trig_raw,
    output logic [1:0]                  pwm_out,
    output logic [1:0]                  trig_out,
    output logic [1:0]                  half_run,
    output logic [1:0]                  capture_edge,
    output logic                        clock_count_enable,
    output logic                        mode_wide,
    output logic                        mode_clock,
    output logic                        mode_split,
    output logic                        timer_irq
);
    import dtc_pkg::*;

    typedef struct packed {
        logic [2:0]        global_configuration;
        logic [14:0]       timer_control;
        logic [EVT_W-1:0]  interrupt_enable_mask;
        logic [EVT_W-1:0]  raw_event_status;
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } dtc_state_type;

    dtc_state_type     st;
    dtc_state_type     next_st;
    logic              aw_take;
    logic              w_take;
    logic              wr_go;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic [31:0]       bytes;
    logic [31:0]       ctl_word;
    logic [EVT_W-1:0]  clr_bits;
    logic [EVT_W-1:0]  masked_event_status;

    dtc_half_if hif [NUM_HALVES] ();

    // Byte lanes of the write strobe widened to a bit mask
    function automatic logic [31:0] strb_bits(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : strb_bits

    // Merge a write into a register, touching only enabled, writable bits
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [31:0] lanes, input logic [31:0] wmask);
        logic [31:0] keep;
        keep = lanes & wmask;
        return (old & ~keep) | (data & keep);
    endfunction : merge

    // Handshake readies; one write and one read in flight at most
    assign s_axi_awready = ~st.aw_held & ~st.bvalid;
    assign s_axi_wready  = ~st.w_held & ~st.bvalid;
    assign s_axi_arready = ~st.rvalid;
    assign aw_take       = s_axi_awvalid & s_axi_awready;
    assign w_take        = s_axi_wvalid & s_axi_wready;
    assign wr_go         = (st.aw_held | aw_take) & (st.w_held | w_take);
    assign wr_addr       = st.aw_held ? st.aw_addr : s_axi_awaddr;
    assign wr_data       = st.w_held ? st.w_data : s_axi_wdata;
    assign wr_strb       = st.w_held ? st.w_strb : s_axi_wstrb;
    assign bytes         = strb_bits(wr_strb);
    assign ctl_word      = {17'h00000, st.timer_control};

    // Masked view is a pure AND, so it needs no storage of its own
    assign masked_event_status = st.raw_event_status & st.interrupt_enable_mask;

    // Clear bits: only byte lanes that were written can clear
    assign clr_bits = (wr_go && wr_addr == OFF_CLR) ?
                      (wr_data[EVT_W-1:0] & bytes[EVT_W-1:0] & EVT_WR_MASK) : '0;

    always_comb begin
        next_st = st;
        // Address and data may arrive in either order
        if (aw_take) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = RESP_OKAY;
            case (wr_addr)
                OFF_CFG: begin
                    next_st.global_configuration =
                        3'(merge({29'h0, st.global_configuration}, wr_data, bytes,
                                 CFG_WR_MASK));
                end
                OFF_CTL: begin
                    // Reserved bits stay zero whatever is written
                    next_st.timer_control =
                        15'(merge(ctl_word, wr_data, bytes, CTL_WR_MASK));
                end
                OFF_MASK: begin
                    next_st.interrupt_enable_mask =
                        EVT_W'(merge({21'h0, st.interrupt_enable_mask}, wr_data, bytes,
                                     {21'h0, EVT_WR_MASK}));
                end
                OFF_CLR, OFF_RAW, OFF_MIS: begin
                    next_st.bresp = RESP_OKAY; // Status is read-only; clear is below
                end
                default: begin
                    next_st.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // Set wins over a clear landing in the same cycle
        next_st.raw_event_status = (st.raw_event_status & ~clr_bits) |
                                   (timer_event & EVT_WR_MASK);
        // Read data registered, answer one cycle after the address
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            case (s_axi_araddr)
                OFF_CFG:  next_st.rdata = {29'h0, st.global_configuration};
                OFF_CTL:  next_st.rdata = ctl_word;
                OFF_MASK: next_st.rdata = {21'h0, st.interrupt_enable_mask};
                OFF_RAW:  next_st.rdata = {21'h0, st.raw_event_status};
                OFF_MIS:  next_st.rdata = {21'h0, masked_event_status};
                OFF_CLR:  next_st.rdata = 32'h0000_0000;
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st                       <= '0;
            st.global_configuration  <= CFG_RST;
            st.timer_control         <= CTL_RST;
            st.interrupt_enable_mask <= EVT_RST;
            st.raw_event_status      <= EVT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp  = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp  = st.rresp;
    assign s_axi_rdata  = st.rdata;

    // Configuration decode; reserved codes select nothing
    assign mode_wide  = st.global_configuration == CFG_WIDE;
    assign mode_clock = st.global_configuration == CFG_CLOCK;
    assign mode_split = st.global_configuration[CFG_SPLIT_BIT];

    // Clock counter only runs in clock configuration with its enable set
    assign clock_count_enable = st.timer_control[CTL_CLK_EN] & mode_clock;

    // Single controller interrupt, level, from registered status
    assign timer_irq = |masked_event_status;

    // Per half: control fields out, run and capture back
    for (genvar g = 0; g < NUM_HALVES; g++) begin : g_half
        localparam int B = g * CTL_HALF_STRIDE;
        assign hif[g].enable   = st.timer_control[B + CTL_EN];
        assign hif[g].stall_en = st.timer_control[B + CTL_STALL];
        assign hif[g].edge_sel = dtc_edge_type'(st.timer_control[B + CTL_EDGE +: 2]);
        assign hif[g].trig_en  = st.timer_control[B + CTL_TRIG];
        assign hif[g].pwm_pol  = st.timer_control[B + CTL_PWM];
        assign half_run[g]     = hif[g].run;
        assign capture_edge[g] = hif[g].cap_edge;

        dtc_half u_half (
            .aclk        (aclk),
            .aresetn     (aresetn),
            .capture_pin (capture_pin[g]),
            .pwm_raw     (pwm_raw[g]),
            .trig_raw    (trig_raw[g]),
            .debug_halt  (debug_halt),
            .pwm_out     (pwm_out[g]),
            .trig_out    (trig_out[g]),
            .h           (hif[g])
        );
    end

    // Write response: raised one cycle after both halves of a write are in
    sequence s_write_in;
        wr_go;
    endsequence
    sequence s_resp_up;
        s_axi_bvalid;
    endsequence

    property p_write_resp;
        @(posedge aclk) disable iff (!aresetn)
        s_write_in |=> s_resp_up;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("no write response");

    property p_bvalid_hold;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");

    property p_ctl_reserved;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr) == OFF_CTL
            |-> (s_axi_rdata & ~CTL_WR_MASK) == 32'h0000_0000;
    endproperty
    a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved ctl bit set");

    property p_mask_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_go && wr_addr == OFF_MASK && wr_strb == 4'hf)
            |=> st.interrupt_enable_mask == ($past(wr_data[EVT_W-1:0]) & EVT_WR_MASK);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask not stored");

    // A clear landing right after the event may legally drop the bit
    sequence s_cap_set;
        timer_event[EVT_B_CAPTURE] ##1 !clr_bits[EVT_B_CAPTURE];
    endsequence

    property p_raw_set;
        @(posedge aclk) disable iff (!aresetn)
        s_cap_set |-> st.raw_event_status[EVT_B_CAPTURE] [*2];
    endproperty
    a_raw_set: assert property (p_raw_set) else $error("event lost");

    property p_raw_clear;
        @(posedge aclk) disable iff (!aresetn)
        (clr_bits[EVT_A_TIMEOUT] && !timer_event[EVT_A_TIMEOUT])
            |=> !st.raw_event_status[EVT_A_TIMEOUT];
    endproperty
    a_raw_clear: assert property (p_raw_clear) else $error("clear ignored");

    property p_irq_source;
        @(posedge aclk) disable iff (!aresetn)
        (timer_event[EVT_CLOCK] && st.interrupt_enable_mask[EVT_CLOCK] && !clr_bits[EVT_CLOCK])
            |=> timer_irq;
    endproperty
    a_irq_source: assert property (p_irq_source) else $error("irq missing");

    property p_clock_gate;
        @(posedge aclk) disable iff (!aresetn)
        (wr_go && wr_addr == OFF_CTL && wr_strb == 4'hf && !wr_data[CTL_CLK_EN])
            |=> !clock_count_enable;
    endproperty
    a_clock_gate: assert property (p_clock_gate) else $error("clock count leaked");

    property p_reset_ctl;
        @(posedge aclk)
        !aresetn |=> (st.timer_control == CTL_RST && st.interrupt_enable_mask == EVT_RST);
    endproperty
    a_reset_ctl: assert property (p_reset_ctl) else $error("control not reset");

endmodule : dtc_top

//--- tb_dual_timer_control_irq_mask.sv
module tb_dual_timer_control_irq_mask import dtc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk;
    logic        aresetn;
    logic [11:0] awaddr;
    logic [11:0] araddr;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [10:0] timer_event;
    logic        debug_halt;
    logic [1:0]  capture_pin;
    logic [1:0]  pwm_raw;
    logic [1:0]  trig_raw;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [1:0]  pwm_out;
    logic [1:0]  trig_out;
    logic [1:0]  half_run;
    logic [1:0]  capture_edge;
    logic        cce;
    logic        wide;
    logic        clk_mode;
    logic        split;
    logic        timer_irq;
    int          bad_count = 0;
    int          n_checks = 0;
    int          cyc = 0;

    dtc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_event(timer_event), .debug_halt(debug_halt),
        .capture_pin(capture_pin), .pwm_raw(pwm_raw), .trig_raw(trig_raw),
        .pwm_out(pwm_out), .trig_out(trig_out), .half_run(half_run),
        .capture_edge(capture_edge), .clock_count_enable(cce), .mode_wide(wide),
        .mode_clock(clk_mode), .mode_split(split), .timer_irq(timer_irq));

    task automatic end_sim;
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Handshakes judged at the falling edge, where nothing is moving
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        b_hs = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hf;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = awvalid & awready;
            w_hs  = wvalid & wready;
            b_hs  = bvalid;
            r     = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0]  r;
        r_hs = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = arvalid & arready;
            r_hs  = rvalid;
            d     = rdata;
            r     = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk(d, exp);
        chk(32'(r), 32'(er));
    endtask : rd

    // Reset values, writable masks, unmapped place
    task automatic t_regs;
        logic [1:0] r;
        rd(OFF_CTL, 32'h0, RESP_OKAY);
        rd(OFF_MASK, 32'h0, RESP_OKAY);
        wr(OFF_CTL, 32'hffff_ffff, r);
        rd(OFF_CTL, 32'h0000_6f7f, RESP_OKAY);
        wr(OFF_MASK, 32'hffff_ffff, r);
        rd(OFF_MASK, 32'h0000_070f, RESP_OKAY);
        wr(OFF_MASK, 32'h0, r);
        wr(OFF_CTL, 32'h0, r);
        wr(12'h100, 32'h1, r);
        chk(32'(r), 32'(RESP_SLVERR));
        rd(12'h100, 32'h0, RESP_SLVERR);
    endtask : t_regs

    // Polarity, trigger gating, enable and stall per half
    task automatic t_pins;
        logic [1:0]  r;
        logic [15:0] ctl [9] = '{16'h0000, 16'h4040, 16'h2020, 16'h0101, 16'h0303,
                                 16'h0103, 16'h0303, 16'h0040, 16'h2000};
        logic        hlt [9] = '{1, 1, 1, 1, 1, 1, 0, 0, 0};
        logic [5:0]  exp [9] = '{6'h10, 6'h20, 6'h1c, 6'h13, 6'h10, 6'h12, 6'h13,
                                 6'h00, 6'h18};
        pwm_raw  <= 2'h1;
        trig_raw <= 2'h3;
        for (int i = 0; i < 9; i++) begin
            @(posedge aclk);
            debug_halt <= hlt[i];
            wr(OFF_CTL, {16'h0, ctl[i]}, r);
            repeat (2) @(negedge aclk);
            chk(32'({pwm_out, trig_out, half_run}), 32'(exp[i]));
        end
        @(posedge aclk);
        debug_halt <= 1'b0;
    endtask : t_pins

    task automatic pin_step(input int h, input logic v, output int n);
        n = 0;
        @(posedge aclk);
        capture_pin[h] <= v;
        repeat (6) begin
            @(negedge aclk);
            if (capture_edge[h] === 1'b1) n++;
        end
    endtask : pin_step

    // Every edge code on both halves, last pass with the half disabled
    task automatic t_cap;
        logic [1:0] r;
        logic [1:0] c;
        logic       en;
        int         nr, nf;
        for (int h = 0; h < 2; h++) begin
            for (int i = 0; i < 5; i++) begin
                c  = 2'(i);
                en = (i < 4);
                wr(OFF_CTL, 32'({c, 1'b0, en}) << (8 * h), r);
                pin_step(h, 1'b1, nr);
                pin_step(h, 1'b0, nf);
                chk(32'(nr), 32'(en && (c == 2'h0 || c == 2'h3)));
                chk(32'(nf), 32'(en && (c == 2'h1 || c == 2'h3)));
            end
        end
    endtask : t_cap

    // Configuration decode and the clock counter enable
    task automatic t_cfg;
        logic [1:0] r;
        logic [2:0] c;
        wr(OFF_CTL, 32'h10, r);
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(OFF_CFG, 32'(c), r);
            @(negedge aclk);
            chk(32'({cce, wide, clk_mode, split}),
                32'({c == 3'h1, c == 3'h0, c == 3'h1, c[2]}));
        end
        wr(OFF_CFG, 32'h1, r);
        wr(OFF_CTL, 32'h0, r);
        @(negedge aclk);
        chk(32'(cce), 32'h0);
    endtask : t_cfg

    // Raw status, masking, interrupt line and clearing
    task automatic t_irq;
        logic [1:0] r;
        @(posedge aclk);
        timer_event <= 11'h7ff;
        @(posedge aclk);
        timer_event <= 11'h000;
        rd(OFF_RAW, 32'h70f, RESP_OKAY);
        rd(OFF_MIS, 32'h0, RESP_OKAY);
        @(negedge aclk);
        chk(32'(timer_irq), 32'h0);
        wr(OFF_MASK, 32'h100, r);
        @(negedge aclk);
        chk(32'(timer_irq), 32'h1);
        rd(OFF_MIS, 32'h100, RESP_OKAY);
        wr(OFF_CLR, 32'h100, r);
        rd(OFF_RAW, 32'h60f, RESP_OKAY);
        @(negedge aclk);
        chk(32'(timer_irq), 32'h0);
        wr(OFF_CLR, 32'hffff_ffff, r);
        rd(OFF_RAW, 32'h0, RESP_OKAY);
    endtask : t_irq

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Hang guard, generous against roughly three hundred cycles of work
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
        {wdata, wstrb, timer_event, debug_halt, capture_pin, pwm_raw, trig_raw} = '0;
        aresetn = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_pins();
        t_cap();
        t_cfg();
        t_irq();
        end_sim();
    end

endmodule : tb_dual_timer_control_irq_mask
